// file: caf_filter_control.sv
// filter control registers for filters 8 to 19 with apb access and routing lookup
`timescale 1ns/1ps
`include "caf_defs.svh"

// What this block does
// - a filter takes part in acceptance only while its enable bit is one
// - two-bit mask choice picks acceptance mask zero to three directly
// - five-bit destination names receive fifo 0 to 31 by its binary value
// - mask choice and destination change only while the filter is disabled
// - all bits read and write, and clear to zero at reset
// - per byte: enable on top, mask choice next, destination in low five bits
// - four filters per register, lowest filter in bits 7:0; 12-15 then 16-19
// - the preceding register holds filters 8 to 11, filter 8 lowest
module caf_filter_control #(
    parameter int FIRST_FILTER = 8,
    parameter int NUM_REGS = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire caf_pkg::caf_hit_t hit,
    output caf_pkg::caf_route_t route,
    output logic [4*NUM_REGS-1:0] filter_enabled,
    output logic [1:0] mask_of_filter [4*NUM_REGS],
    output logic [4:0] fifo_of_filter [4*NUM_REGS]
);

    // ----------------------------------------
    // local sizes
    // ----------------------------------------
    // filters outside this range belong to other control registers
    localparam int NUM_FILTERS = 4 * NUM_REGS;
    localparam int LAST_FILTER = FIRST_FILTER + NUM_FILTERS - 1;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // returns register index, or NUM_REGS for an unmapped address
    function automatic int unsigned reg_index(input logic [11:0] addr);
        unique case (addr)
            `CAF_OFS_FILTER_CONTROL_8_TO_11: reg_index = 0;
            `CAF_OFS_FILTER_CONTROL_12_TO_15: reg_index = 1;
            `CAF_OFS_FILTER_CONTROL_16_TO_19: reg_index = 2;
            default: reg_index = NUM_REGS;
        endcase
    endfunction : reg_index

    // true when the address names one of the control registers
    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (reg_index(addr) < NUM_REGS);
    endfunction : is_mapped

    // ----------------------------------------
    // field extractors
    // ----------------------------------------
    // field positions inside one filter byte
    function automatic logic byte_on(input logic [7:0] wbyte);
        byte_on = wbyte[`CAF_BIT_ON];
    endfunction : byte_on

    function automatic logic [1:0] byte_mask(input logic [7:0] wbyte);
        byte_mask = wbyte[`CAF_MSK_HI:`CAF_MSK_LO];
    endfunction : byte_mask

    function automatic logic [4:0] byte_fifo(input logic [7:0] wbyte);
        byte_fifo = wbyte[`CAF_DST_HI:`CAF_DST_LO];
    endfunction : byte_fifo

    // ----------------------------------------
    // filter helpers
    // ----------------------------------------
    // flat position of a filter byte, filter FIRST_FILTER at zero
    function automatic int unsigned flat_pos(input int unsigned r, input int unsigned b);
        flat_pos = 4 * r + b;
    endfunction : flat_pos

    // merges one write byte into a filter, guarding the locked fields
    function automatic caf_pkg::caf_filter_t merge_byte(
        input caf_pkg::caf_filter_t cur,
        input logic locked,
        input logic [7:0] wbyte
    );
        caf_pkg::caf_filter_t res;
        res = cur;
        res.filter_on_bit = byte_on(wbyte);
        // clearing the enable and reprogramming takes two writes
        if (!locked) begin
            res.mask_choice_field = byte_mask(wbyte);
            res.fifo_destination_field = byte_fifo(wbyte);
        end
        merge_byte = res;
    endfunction : merge_byte

    // ----------------------------------------
    // bus qualifiers
    // ----------------------------------------
    int unsigned sel_idx;
    logic mapped;
    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic rd_setup;

    assign sel_idx = reg_index(paddr);
    assign mapped = is_mapped(paddr);
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_access = access_phase && pwrite;
    assign rd_setup = setup_phase && !pwrite;
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    caf_pkg::caf_word_t ctrl [NUM_REGS];
    caf_pkg::caf_word_t next_ctrl [NUM_REGS];
    logic [3:0] byte_we [NUM_REGS];

    // unmapped addresses write nothing
    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            byte_we[r] = 4'h0;
            if (wr_access && mapped && (sel_idx == r)) begin
                byte_we[r] = pstrb;
            end
        end
    end

    // ----------------------------------------
    // field lock
    // ----------------------------------------
    logic [3:0] byte_locked [NUM_REGS];

    // the enable stored before a write decides the lock
    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            for (int b = 0; b < 4; b++) begin
                byte_locked[r][b] = ctrl[r][b].filter_on_bit;
            end
        end
    end

    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            next_ctrl[r] = ctrl[r];
            for (int b = 0; b < 4; b++) begin
                if (byte_we[r][b]) begin
                    next_ctrl[r][b] = merge_byte(ctrl[r][b], byte_locked[r][b],
                        pwdata[8*b +: 8]);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                ctrl[r] <= `CAF_RST_CONTROL;
            end
        end else begin
            for (int r = 0; r < NUM_REGS; r++) begin
                ctrl[r] <= next_ctrl[r];
            end
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [31:0] next_prdata;
    logic [31:0] read_word;

    // plain mux of the stored words
    always_comb begin
        read_word = 32'h0000_0000;
        for (int r = 0; r < NUM_REGS; r++) begin
            if (sel_idx == r) begin
                read_word = ctrl[r];
            end
        end
    end

    // registered, so it is captured during setup for the access edge
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (rd_setup && mapped) begin
            next_prdata = read_word;
        end else if (access_phase) begin
            next_prdata = prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // bus error
    // ----------------------------------------
    logic next_pslverr;

    // unmapped addresses answer with an error for reads and writes alike
    always_comb begin
        next_pslverr = 1'b0;
        if (setup_phase) begin
            next_pslverr = !mapped;
        end else if (access_phase) begin
            next_pslverr = pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= next_pslverr;
        end
    end

    // ----------------------------------------
    // settings toward the match engine
    // ----------------------------------------
    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            for (int b = 0; b < 4; b++) begin
                filter_enabled[flat_pos(r, b)] = ctrl[r][b].filter_on_bit;
            end
        end
    end

    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            for (int b = 0; b < 4; b++) begin
                mask_of_filter[flat_pos(r, b)] = ctrl[r][b].mask_choice_field;
            end
        end
    end

    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            for (int b = 0; b < 4; b++) begin
                fifo_of_filter[flat_pos(r, b)] = ctrl[r][b].fifo_destination_field;
            end
        end
    end

    // ----------------------------------------
    // routing lookup for a candidate hit
    // ----------------------------------------
    logic hit_in_range;
    int unsigned hit_pos;
    caf_pkg::caf_filter_t hit_filter;

    // combinational so the match engine sees the answer in the same cycle
    assign hit_in_range = hit.valid
        && (int'(hit.filter_index) >= FIRST_FILTER)
        && (int'(hit.filter_index) <= LAST_FILTER);

    always_comb begin
        hit_pos = 0;
        if (hit_in_range) begin
            hit_pos = unsigned'(int'(hit.filter_index) - FIRST_FILTER);
        end
    end

    always_comb begin
        hit_filter = '0;
        for (int r = 0; r < NUM_REGS; r++) begin
            for (int b = 0; b < 4; b++) begin
                if (hit_in_range && (hit_pos == flat_pos(r, b))) begin
                    hit_filter = ctrl[r][b];
                end
            end
        end
    end

    // out-of-range or disabled filters give no accept and no fifo write
    always_comb begin
        route = '0;
        if (hit_filter.filter_on_bit) begin
            route.accept = 1'b1;
            route.mask_choice_field = hit_filter.mask_choice_field;
            route.fifo_destination_field = hit_filter.fifo_destination_field;
        end
    end

endmodule : caf_filter_control

// file: caf_defs.svh
// offsets, field positions and reset values of the filter control registers
`ifndef CAF_DEFS_SVH
`define CAF_DEFS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CAF_OFS_FILTER_CONTROL_8_TO_11 12'h000
`define CAF_OFS_FILTER_CONTROL_12_TO_15 12'h004
`define CAF_OFS_FILTER_CONTROL_16_TO_19 12'h008

// ----------------------------------------
// fields inside one filter byte
// ----------------------------------------
`define CAF_BIT_ON 7
`define CAF_MSK_HI 6
`define CAF_MSK_LO 5
`define CAF_DST_HI 4
`define CAF_DST_LO 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CAF_RST_CONTROL 32'h0000_0000

`endif

// file: caf_pkg.sv
// types shared by the acceptance filter control block
package caf_pkg;

    // one filter's settings, laid out exactly as its byte lane
    typedef struct packed {
        logic filter_on_bit;
        logic [1:0] mask_choice_field;
        logic [4:0] fifo_destination_field;
    } caf_filter_t;

    // one register: four filters, lowest number in the low byte
    typedef caf_filter_t [3:0] caf_word_t;

    // one candidate match presented by the match engine
    typedef struct packed {
        logic valid;
        logic [4:0] filter_index;
    } caf_hit_t;

    // what the acceptance path gets back for a candidate
    typedef struct packed {
        logic accept;
        logic [1:0] mask_choice_field;
        logic [4:0] fifo_destination_field;
    } caf_route_t;

endpackage : caf_pkg

// file: caf_filter_control_asserts.sv
// concurrent checks on the filter control block ports
`timescale 1ns/1ps
module caf_filter_control_asserts #(
    parameter int NUM_REGS = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire caf_pkg::caf_hit_t hit,
    input wire caf_pkg::caf_route_t route,
    input wire logic [4*NUM_REGS-1:0] filter_enabled,
    input wire logic [4:0] fifo_of_filter [4*NUM_REGS]
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    assign wr = psel && penable && pwrite;
    property p_lock; filter_enabled[0] |=> $stable(fifo_of_filter[0]); endproperty
    a_lock: assert property (p_lock) else $error("field moved while on");
    property p_acc; hit.valid && hit.filter_index == 5'h08 |-> route.accept == filter_enabled[0];
    endproperty
    a_acc: assert property (p_acc) else $error("accept not enable");
    property p_off; hit.filter_index == 5'h13 && !filter_enabled[11] |-> !route.accept; endproperty
    a_off: assert property (p_off) else $error("disabled accepted");
    property p_fifo; route.accept && hit.filter_index == 5'h13
        |-> route.fifo_destination_field == fifo_of_filter[11]; endproperty
    a_fifo: assert property (p_fifo) else $error("wrong fifo");
    property p_wr10; wr && paddr == 12'h000 && pstrb[2] && !filter_enabled[2]
        |=> fifo_of_filter[2] == $past(pwdata[20:16]); endproperty
    a_wr10: assert property (p_wr10) else $error("filter 10 fifo");
    property p_wr19; wr && paddr == 12'h008 && pstrb[3] && !filter_enabled[11]
        |=> fifo_of_filter[11] == $past(pwdata[28:24]); endproperty
    a_wr19: assert property (p_wr19) else $error("filter 19 fifo");
    property p_en; wr && paddr == 12'h004 && pstrb[0] |=> filter_enabled[4] == $past(pwdata[7]);
    endproperty
    a_en: assert property (p_en) else $error("enable bit");
    property p_keep; wr && paddr == 12'h004 && !pstrb[0] |=> $stable(filter_enabled[4]); endproperty
    a_keep: assert property (p_keep) else $error("unstrobed byte");
endmodule : caf_filter_control_asserts
bind caf_filter_control caf_filter_control_asserts #(.NUM_REGS(NUM_REGS)) u_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .hit, .route, .filter_enabled,
    .fifo_of_filter);

// file: tb_top.sv
// self-checking bench for the filter control block
`timescale 1ns/1ps
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0, a, fe;
    logic [31:0] pwdata = '0, prdata, r, seed = 32'h0000_337a, m [3];
    logic [3:0] pstrb = '0;
    logic [7:0] bt, ex;
    logic [4:0] ix;
    logic [1:0] mk [12];
    logic [4:0] ff [12];
    logic [7:0] rq [$];
    caf_pkg::caf_hit_t hit = '0;
    caf_pkg::caf_route_t route;
    logic [32:0] q [$];
    int error_cnt = 0, samples_checked = 0;
    always #10 pclk = ~pclk;
    caf_filter_control uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .hit, .route, .filter_enabled(fe),
        .mask_of_filter(mk), .fifo_of_filter(ff));
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task ck(input logic [32:0] s, input logic [32:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask : ck
    task results();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    // ----
    // apb master, one idle cycle between transfers
    // ----
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [3:0] s);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk) penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            results();
        end
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
        if (q.size() == 0) error_cnt++;
        else ck({pslverr, prdata}, q.pop_front());
    end
    // route and exported settings, looked at mid-cycle while the hit stands
    always @(negedge pclk) if (hit.valid) begin
        if (rq.size() == 0) error_cnt++;
        else begin
            ex = rq.pop_front();
            ix = hit.filter_index - 5'd8;
            ck(33'(route.accept), 33'(ex[7]));
            ck(33'(route), 33'(ex[7] ? ex : 8'h00));
            if (hit.filter_index > 5'd7 && hit.filter_index < 5'd20)
                ck(33'({fe[ix], mk[ix], ff[ix]}), 33'(ex));
        end
    end
    initial begin
        for (int i = 0; i < 3; i++) m[i] = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            q.push_back(i < 3 ? 33'h0_0000_0000 : 33'h1_0000_0000);
            apb(0, 12'(4 * i), '0, '0);
        end
        for (int i = 0; i < 60; i++) begin
            r = xs();
            a = 12'(4 * (r % 4));
            r = xs();
            // enable stored before the write freezes bits 6:0
            if (a < 12) for (int b = 0; b < 4; b++) if (r[b]) m[a/4][8*b+:8] = m[a/4][8*b+7] ?
                {seed[8*b+7], m[a/4][8*b+:7]} : seed[8*b+:8];
            apb(1, a, seed, r[3:0]);
            q.push_back(a < 12 ? {1'b0, m[a/4]} : 33'h1_0000_0000);
            apb(0, a, '0, '0);
        end
        for (int k = 0; k < 2; k++) begin
            for (int f = 3; f < 21; f++) begin
                bt = (f > 7 && f < 20) ? m[(f-8)/4][8*((f-8)%4)+:8] : 8'h00;
                rq.push_back(bt);
                hit <= {1'b1, 5'(f)};
                @(posedge pclk);
            end
            // mid-run reset: every filter must come back disabled and zero
            hit <= '0;
            presetn <= 0;
            for (int i = 0; i < 3; i++) m[i] = '0;
            repeat (2) @(posedge pclk);
            presetn <= 1;
            @(posedge pclk);
            for (int i = 0; i < 3; i++) begin
                q.push_back(33'h0_0000_0000);
                apb(0, 12'(4 * i), '0, '0);
            end
        end
        results();
    end
endmodule : tb_top
